// *** hw/mux_scan_sequencer.sv ***
// Scanned acquisition sequencer driving device and external multiplexer selects
`timescale 1ns/100ps

// What this block does
// - Internal counter steps all multiplexers automatically
// - One unit: four sub-channels per entry
// - Two units: four each, unit one then two
// - Four units: four each, units one to four
// - Channel n selects sub-channels 4n to 4n+3
// - Entries visited in programmed channel list order
// - One scan visits each listed entry once
// - Scan count sets readings before stopping
// - Scan period sets start-to-start scan spacing
// - Channel period sets conversion spacing within scan
module mux_scan_sequencer
  import scan_seq_pkg::*;
#(
  parameter int LIST_LEN = LIST_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Configuration, held steady while busy
  input wire logic [1:0] i_units,
  input wire logic [LIST_IDX_W-1:0] i_list_last,
  input wire logic [SCAN_CNT_W-1:0] i_scan_count,
  input wire logic [CNT_W-1:0] i_chan_period,
  input wire logic [CNT_W-1:0] i_scan_period,
  // Channel list write port
  input wire logic i_list_we,
  input wire logic [LIST_IDX_W-1:0] i_list_addr,
  input wire logic [DEV_CH_W-1:0] i_list_data,
  // Acquisition control
  input wire logic i_start,
  input wire logic i_stop,
  // Converter handshake
  output logic o_conv_start,
  input wire logic i_conv_done,
  // Multiplexer selects
  output logic [DEV_CH_W-1:0] o_dev_chan,
  output logic [UNIT_W-1:0] o_ext_unit,
  output logic [EXT_CH_W-1:0] o_ext_chan,
  // Status
  output logic o_busy,
  output logic o_scan_done,
  output logic o_acq_done,
  output logic [SCAN_CNT_W-1:0] o_scans_taken
);

  // ----------------------------------------
  // Channel list memory
  // ----------------------------------------
  logic [DEV_CH_W-1:0] list_mem [LIST_LEN];

  // Writes reach the very next lookup, even in the middle of a pass
  always_ff @(posedge i_clk) begin
    if (i_list_we) begin
      list_mem[i_list_addr] <= i_list_data;
    end
  end

  // ----------------------------------------
  // Position counter
  // ----------------------------------------
  seq_step_if step_if ();

  mux_address_counter u_counter (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .step_if(step_if)
  );

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  seq_state_t state_reg, state_next;
  logic [CNT_W-1:0] chan_tmr_reg, chan_tmr_next;
  logic [CNT_W-1:0] scan_tmr_reg, scan_tmr_next;
  logic [SCAN_CNT_W-1:0] scans_reg, scans_next;
  logic [1:0] units_reg, units_next;
  logic [LIST_IDX_W-1:0] last_reg, last_next;
  logic conv_reg, conv_next;
  logic scan_done_reg, scan_done_next;
  logic acq_done_reg, acq_done_next;
  logic [DEV_CH_W-1:0] dev_reg, dev_next;
  logic [UNIT_W-1:0] unit_reg, unit_next;
  logic [EXT_CH_W-1:0] ext_reg, ext_next;
  logic step;
  logic clear;

  // External sub-channel is four times the device channel plus offset
  function automatic logic [EXT_CH_W-1:0] ext_index(input logic [DEV_CH_W-1:0] ch,
                                                    input logic [SUB_W-1:0] sub);
    ext_index = {ch, sub};
  endfunction

  // Counter ports; units and list length latched at start for a stable pass
  assign step_if.clear = clear;
  assign step_if.step = step;
  assign step_if.units = units_reg;
  assign step_if.last_idx = last_reg;

  // Next-state logic: one conversion per step, timers pace the steps
  always_comb begin
    state_next = state_reg;
    chan_tmr_next = chan_tmr_reg;
    scan_tmr_next = scan_tmr_reg;
    scans_next = scans_reg;
    units_next = units_reg;
    last_next = last_reg;
    conv_next = 1'b0;
    scan_done_next = 1'b0;
    acq_done_next = 1'b0;
    step = 1'b0;
    clear = 1'b0;
    // Selects track the counter position, looked up through the list
    dev_next = list_mem[step_if.list_idx];
    unit_next = step_if.unit;
    ext_next = ext_index(dev_next, step_if.sub);
    if (scan_tmr_reg != TIMER_RESET) begin
      scan_tmr_next = scan_tmr_reg - 1'b1;
    end
    if (chan_tmr_reg != TIMER_RESET) begin
      chan_tmr_next = chan_tmr_reg - 1'b1;
    end
    case (state_reg)
      ST_IDLE: begin
        if (i_start && i_scan_count != SCAN_DONE_RESET) begin
          clear = 1'b1;
          units_next = i_units;
          last_next = i_list_last;
          scans_next = SCAN_DONE_RESET;
          state_next = ST_SCAN_WAIT;
          scan_tmr_next = TIMER_RESET;
        end
      end
      ST_SCAN_WAIT: begin
        // Start-to-start scan pacing; a scan period shorter than the scan runs back to back
        if (scan_tmr_reg == TIMER_RESET) begin
          scan_tmr_next = i_scan_period;
          chan_tmr_next = i_chan_period;
          conv_next = 1'b1;
          state_next = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (i_conv_done) begin
          step = 1'b1;
          if (step_if.scan_end) begin
            scan_done_next = 1'b1;
            scans_next = scans_reg + 1'b1;
            if (scans_reg + 1'b1 == i_scan_count) begin
              acq_done_next = 1'b1;
              state_next = ST_IDLE;
            end else begin
              state_next = ST_SCAN_WAIT;
            end
          end else begin
            state_next = ST_CH_WAIT;
          end
        end
      end
      ST_CH_WAIT: begin
        // Inter-channel spacing measured from the previous conversion start
        if (chan_tmr_reg == TIMER_RESET) begin
          chan_tmr_next = i_chan_period;
          conv_next = 1'b1;
          state_next = ST_CONVERT;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // Abort leaves the multiplexers where they are unless it meets a conversion done, which still steps them
    if (i_stop && state_reg != ST_IDLE) begin
      state_next = ST_IDLE;
      conv_next = 1'b0;
      acq_done_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_reg <= ST_IDLE;
      chan_tmr_reg <= TIMER_RESET;
      scan_tmr_reg <= TIMER_RESET;
      scans_reg <= SCAN_DONE_RESET;
      units_reg <= UNITS_NONE;
      last_reg <= '0;
      conv_reg <= 1'b0;
      scan_done_reg <= 1'b0;
      acq_done_reg <= 1'b0;
      dev_reg <= '0;
      unit_reg <= '0;
      ext_reg <= '0;
    end else begin
      state_reg <= state_next;
      chan_tmr_reg <= chan_tmr_next;
      scan_tmr_reg <= scan_tmr_next;
      scans_reg <= scans_next;
      units_reg <= units_next;
      last_reg <= last_next;
      conv_reg <= conv_next;
      scan_done_reg <= scan_done_next;
      acq_done_reg <= acq_done_next;
      dev_reg <= dev_next;
      unit_reg <= unit_next;
      ext_reg <= ext_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_conv_start = conv_reg;
  assign o_dev_chan = dev_reg;
  assign o_ext_unit = unit_reg;
  assign o_ext_chan = ext_reg;
  assign o_busy = (state_reg != ST_IDLE);
  assign o_scan_done = scan_done_reg;
  assign o_acq_done = acq_done_reg;
  assign o_scans_taken = scans_reg;

endmodule

// *** pkg/scan_seq_pkg.sv ***
// Constants and types shared by the external multiplexer scan sequencer
package scan_seq_pkg;

  // ----------------------------------------
  // Geometry of the device and external units
  // ----------------------------------------
  localparam int DEV_CHANNELS = 16;
  localparam int DEV_CH_W = 4;
  localparam int SUB_PER_UNIT = 4;
  localparam int SUB_W = 2;
  localparam int UNIT_W = 2;
  localparam int EXT_CH_W = 6;
  localparam int LIST_DEPTH = 16;
  localparam int LIST_IDX_W = 4;
  localparam int CNT_W = 16;
  localparam int SCAN_CNT_W = 16;

  // ----------------------------------------
  // Unit-count selector codes
  // ----------------------------------------
  localparam logic [1:0] UNITS_NONE = 2'h0;
  localparam logic [1:0] UNITS_ONE = 2'h1;
  localparam logic [1:0] UNITS_TWO = 2'h2;
  localparam logic [1:0] UNITS_FOUR = 2'h3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [CNT_W-1:0] TIMER_RESET = 16'h0000;
  localparam logic [SCAN_CNT_W-1:0] SCAN_DONE_RESET = 16'h0000;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_CH_WAIT,
    ST_SCAN_WAIT
  } seq_state_t;

endpackage

// *** pkg/seq_step_if.sv ***
// Interface carrying the step request to the address counter and its position back to the sequencer
`timescale 1ns/100ps
interface seq_step_if;
  import scan_seq_pkg::*;
  logic clear;
  logic step;
  logic [1:0] units;
  logic [LIST_IDX_W-1:0] last_idx;
  logic [LIST_IDX_W-1:0] list_idx;
  logic [UNIT_W-1:0] unit;
  logic [SUB_W-1:0] sub;
  logic scan_end;

  modport seq (output clear, output step, output units, output last_idx,
               input list_idx, input unit, input sub, input scan_end);
  modport cnt (input clear, input step, input units, input last_idx,
               output list_idx, output unit, output sub, output scan_end);
endinterface

// *** hw/mux_address_counter.sv ***
// Position counter: list entry, external unit and sub-channel within the unit
`timescale 1ns/100ps
module mux_address_counter
  import scan_seq_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Sequencer side
  seq_step_if.cnt step_if
);

  logic [LIST_IDX_W-1:0] idx_reg, idx_next;
  logic [UNIT_W-1:0] unit_reg, unit_next;
  logic [SUB_W-1:0] sub_reg, sub_next;

  // Highest unit number for the attached unit count
  function automatic logic [UNIT_W-1:0] last_unit(input logic [1:0] units);
    case (units)
      UNITS_TWO: last_unit = 2'h1;
      UNITS_FOUR: last_unit = 2'h3;
      default: last_unit = 2'h0;
    endcase
  endfunction

  logic sub_wrap;
  logic unit_wrap;
  logic list_wrap;

  // Wrap points; with no unit attached every entry is a single conversion
  always_comb begin
    sub_wrap = (step_if.units == UNITS_NONE) || (sub_reg == SUB_W'(SUB_PER_UNIT - 1));
    unit_wrap = sub_wrap && (unit_reg == last_unit(step_if.units));
    list_wrap = unit_wrap && (idx_reg == step_if.last_idx);
  end

  // Sub-channel runs fastest, then unit, then list entry
  always_comb begin
    idx_next = idx_reg;
    unit_next = unit_reg;
    sub_next = sub_reg;
    if (step_if.clear) begin
      idx_next = '0;
      unit_next = '0;
      sub_next = '0;
    end else if (step_if.step) begin
      sub_next = sub_wrap ? '0 : sub_reg + 1'b1;
      if (sub_wrap) begin
        unit_next = unit_wrap ? '0 : unit_reg + 1'b1;
      end
      if (unit_wrap) begin
        idx_next = list_wrap ? '0 : idx_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      idx_reg <= '0;
      unit_reg <= '0;
      sub_reg <= '0;
    end else begin
      idx_reg <= idx_next;
      unit_reg <= unit_next;
      sub_reg <= sub_next;
    end
  end

  assign step_if.list_idx = idx_reg;
  assign step_if.unit = unit_reg;
  assign step_if.sub = sub_reg;
  assign step_if.scan_end = list_wrap;

endmodule

// *** tb/scan_seq_properties.sv ***
// Port-level checks on the scan sequencer
`timescale 1ns/100ps
module scan_seq_properties
  import scan_seq_pkg::*;
(
  // Clock, reset and configuration
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [1:0] i_units,
  // Sequencer outputs
  input wire logic o_conv_start,
  input wire logic [DEV_CH_W-1:0] o_dev_chan,
  input wire logic [UNIT_W-1:0] o_ext_unit,
  input wire logic [EXT_CH_W-1:0] o_ext_chan,
  input wire logic o_busy,
  input wire logic o_acq_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // --------------------------------
  // Selects and spacing
  // --------------------------------
  chk_ext_group: assert property (o_conv_start |-> o_ext_chan[5:2] == o_dev_chan)
    else $error("external channel outside its group");
  chk_idle_quiet: assert property (!o_busy |-> !o_conv_start)
    else $error("conversion started while idle");
  chk_first_conv: assert property ($rose(o_busy) |-> ##1 o_conv_start)
    else $error("first conversion late");
  chk_first_sel: assert property ($rose(o_busy) |=> o_ext_unit == 0 && o_ext_chan[1:0] == 0)
    else $error("scan not opened on first sub-channel");
  chk_conv_gap: assert property (o_conv_start |=> !o_conv_start [*2])
    else $error("conversions too close");
  chk_none_sub: assert property (o_conv_start && i_units == UNITS_NONE |-> o_ext_unit == 0 && o_ext_chan[1:0] == 0)
    else $error("sub-channel moved with no unit");
  chk_one_unit: assert property (o_conv_start && i_units == UNITS_ONE |-> o_ext_unit == 0)
    else $error("unit beyond the only one");
  chk_two_units: assert property (o_conv_start && i_units == UNITS_TWO |-> !o_ext_unit[1])
    else $error("unit beyond the second");
  chk_acq_end: assert property (o_acq_done |=> !o_busy)
    else $error("busy after acquisition end");
endmodule

bind mux_scan_sequencer scan_seq_properties u_props (.i_clk, .i_reset_n, .i_units, .o_conv_start,
  .o_dev_chan, .o_ext_unit, .o_ext_chan, .o_busy, .o_acq_done);

// *** tb/ext_mux_model.sv ***
// Converter and external unit model answering each conversion start
`timescale 1ns/100ps
module ext_mux_model (
  // Clock
  input wire logic i_clk,
  // Conversion handshake
  input wire logic i_conv_start,
  input wire logic [3:0] i_latency,
  output logic o_conv_done
);
  int left = 0;
  initial o_conv_done = 1'b0;
  // Settling plus conversion time; a slow latency lets the channel timer expire first
  always @(posedge i_clk) begin
    o_conv_done <= (left == 1) && !i_conv_start;
    if (i_conv_start) left <= int'(i_latency);
    else if (left > 0) left <= left - 1;
  end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the scan sequencer
`timescale 1ns/100ps
module tb;
  import scan_seq_pkg::*;
  logic clk = 0, rst_n = 0, we = 0, start = 0, stop = 0, done, cs, sd, ad, busy;
  logic [1:0] units = 0, un;
  logic [3:0] last = 0, addr = 0, data = 0, lat = 1, dev;
  logic [15:0] cnt = 1, cper = 0, sper = 0, taken;
  logic [5:0] ext;
  logic [3:0] list [16];
  int errors = 0, checked = 0, k = 0, cyc = 0, t_last = 0, t_scan = 0, sdn = 0, adn = 0;

  mux_scan_sequencer DUT (.i_clk(clk), .i_reset_n(rst_n), .i_units(units), .i_list_last(last),
    .i_scan_count(cnt), .i_chan_period(cper), .i_scan_period(sper), .i_list_we(we), .i_list_addr(addr),
    .i_list_data(data), .i_start(start), .i_stop(stop), .o_conv_start(cs), .i_conv_done(done),
    .o_dev_chan(dev), .o_ext_unit(un), .o_ext_chan(ext), .o_busy(busy), .o_scan_done(sd),
    .o_acq_done(ad), .o_scans_taken(taken));
  ext_mux_model partner (.i_clk(clk), .i_conv_start(cs), .i_latency(lat), .o_conv_done(done));

  initial forever #2.5 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Conversions per list entry for the unit count in use
  function automatic int per_entry();
    return units == UNITS_NONE ? 1 : units == UNITS_FOUR ? 16 : 4 * units;
  endfunction

  // Selects {device, unit, external} for the n-th conversion of a run
  function automatic logic [15:0] exp_sel(input int n);
    int s = n % per_entry();
    logic [3:0] ch = list[(n / per_entry()) % (last + 1)];
    return {4'h0, ch, 2'(s / 4), ch, 2'(s % 4)};
  endfunction

  // Every conversion start: selects against the expansion, spacing against the periods after the first of a run
  always @(posedge clk) begin
    cyc++;
    if (ad) adn++;
    // A scan-done pulse must follow the last conversion of a whole scan
    if (sd) begin
      sdn++;
      chk(16'(k % (per_entry() * (last + 1))), 16'h0);
    end
    if (cs) begin
      chk({4'h0, dev, un, ext}, exp_sel(k));
      if (k % (per_entry() * (last + 1)) == 0) begin
        if (k > 0) chk(16'(cyc - t_scan >= sper), 16'h1);
        t_scan = cyc;
      end else chk(16'(cyc - t_last >= cper), 16'h1);
      t_last = cyc;
      k++;
    end
  end

  // One acquisition, optionally aborted after a number of cycles
  task automatic run(input int abort);
    int w = 0;
    int full;
    k = 0;
    sdn = 0;
    adn = 0;
    @(posedge clk);
    // Configuration written by the caller has settled only now
    full = int'(cnt) * per_entry() * (last + 1);
    start <= 1;
    @(posedge clk);
    start <= 0;
    if (abort > 0) begin
      repeat (abort) @(posedge clk);
      stop <= 1;
      @(posedge clk);
      stop <= 0;
    end
    do begin
      @(negedge clk);
      w++;
    end while (busy !== 1'b0 && w < 5000);
    // Let the monitor count the final done pulses
    @(negedge clk);
    chk(16'(w < 5000), 16'h1);
    chk(16'(adn), 16'h1);
    if (abort > 0) chk(16'(k < full), 16'h1);
    else begin
      chk(taken, cnt);
      chk(16'(sdn), cnt);
      chk(16'(k), 16'(full));
    end
  endtask

  // Watchdog of 60000 cycles, a few times the longest expected set of runs
  initial begin
    #300000;
    errors++;
    results();
  end

  initial begin
    void'($urandom(32'h6E718DC1));
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({12'h0, busy, cs, sd, ad}, 16'h0);
    chk(taken, 16'h0);
    @(posedge clk);
    rst_n <= 1;
    // Every unit code; run 1 is the full reversed list, run 10 is aborted early, run 11 restarts
    for (int r = 0; r < 12; r++) begin
      for (int i = 0; i < 16; i++) begin
        @(posedge clk);
        list[i] = (r == 1) ? 4'(15 - i) : 4'($urandom);
        we <= 1;
        addr <= 4'(i);
        data <= list[i];
      end
      @(posedge clk);
      we <= 0;
      units <= 2'(r % 4);
      last <= (r == 1) ? 4'hF : 4'($urandom % 4);
      cnt <= (r == 1) ? 16'h1 : 16'(1 + $urandom % 3);
      cper <= 16'($urandom % 6);
      sper <= 16'($urandom % 80);
      lat <= 4'(1 + $urandom % 5);
      run(r == 10 ? 10 : 0);
    end
    results();
  end
endmodule
